// [dv/i2c_master_model.sv]
// Purpose: Behavioural bus master for the slave address matcher bench
// Assumes: Open-drain lines with pull-ups resolved by the bench
// Notes:   Waits out clock stretching; a stuck bus is cut by the bench watchdog
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   // Pacing clock and resolved bus lines
   input  wire logic clock,
   input  wire logic scl,
   input  wire logic sda,
   // Pull-downs, high while driving the line low
   output logic      scl_low,
   output logic      sda_low
);
   initial {scl_low, sda_low} = 2'b00;
   // Within send, data only moves while the bus clock is held low, so no false start or stop
   task automatic step(input logic c, input logic d, input int n = 5);
      scl_low = c;
      sda_low = d;
      wait (scl || c);
      repeat (n) @(posedge clock);
      #1;
   endtask : step
   task automatic start;
      step(scl_low, 1'b0);
      step(1'b0, 1'b0);
      step(1'b0, 1'b1);
   endtask : start
   task automatic stop;
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
      step(1'b0, 1'b0);
   endtask : stop
   // Each bit is 2 + 3 clocks low and 5 high: an 80 ns bus clock unless stretched
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         step(1'b1, sda_low, 2);
         step(1'b1, !b[i], 3);
         step(1'b0, !b[i]);
      end
      step(1'b1, sda_low, 2);
      step(1'b1, 1'b0, 3);
      step(1'b0, 1'b0);
      ack = !sda;
      step(1'b1, 1'b0);
   endtask : send
endmodule : i2c_master_model
`default_nettype wire

// [dv/i2c_slave_address_match_chk.sv]
// Purpose: Port-level assertions for the slave address matcher
// Assumes: One clock domain; bound to the top module
// Notes:   Ack timing is judged against the raw bus clock pin
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_address_match_chk (
   // Clock and reset
   input wire logic                    clock,
   input wire logic                    nrst,
   input wire logic                    clk_en,
   // Bus side
   input wire logic                    scl_pin,
   input wire logic                    scl_oe,
   input wire logic                    sda_oe,
   // Software side
   input wire addr_match_pkg::ctrl_s   ctrl,
   input wire logic                    own_address_we,
   input wire logic [7:0]              own_address_wdata,
   input wire logic [7:0]              own_address_reg,
   input wire addr_match_pkg::status_s status
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence s_addr_write;
      clk_en && own_address_we;
   endsequence
   sequence s_ack_high;
      sda_oe && scl_pin;
   endsequence
   sequence s_ack_rise_held;
      $rose(sda_oe) && (ctrl.address_hold_enable || ctrl.data_hold_enable);
   endsequence
   AST_WE_LOADS: assert property (s_addr_write |=> own_address_reg == $past(own_address_wdata))
      else $error("own address not loaded");
   AST_UPD_CLEAR: assert property (s_addr_write ##0 status.update_address_flag |=>
      !status.update_address_flag && !scl_oe) else $error("update flag or stretch not cleared");
   AST_STRETCH_FLAG: assert property (scl_oe == status.update_address_flag)
      else $error("stretch and update flag disagree");
   AST_ACK_LOW_CLOCK: assert property ($rose(sda_oe) |-> !scl_pin)
      else $error("ack driven while bus clock high");
   AST_ACK_HOLD: assert property (s_ack_high |=> sda_oe)
      else $error("ack dropped while bus clock high");
   AST_NO_ACK_FULL: assert property ($rose(sda_oe) |->
      !$past(status.buffer_full_flag) && !$past(status.receive_overflow_flag)) else $error("ack with full buffer");
   AST_LOAD_IRQ: assert property ($rose(status.buffer_full_flag) |-> status.port_interrupt_flag)
      else $error("buffer loaded without interrupt");
   AST_ACK_TIME: assert property (status.acknowledge_time_flag |->
      ctrl.address_hold_enable || ctrl.data_hold_enable) else $error("ack time flag without hold");
   AST_ACK_TIME_SET: assert property (s_ack_rise_held |-> status.acknowledge_time_flag)
      else $error("ack time flag missing while holds enabled");
endmodule : i2c_slave_address_match_chk
bind i2c_slave_address_match i2c_slave_address_match_chk i_chk (.clock(clock), .nrst(nrst), .clk_en(clk_en),
   .scl_pin(scl_pin), .scl_oe(scl_oe), .sda_oe(sda_oe), .ctrl(ctrl), .own_address_we(own_address_we),
   .own_address_wdata(own_address_wdata), .own_address_reg(own_address_reg), .status(status));
`default_nettype wire

// [dv/test_i2c_slave_address_match.sv]
// Purpose: Self-checking bench for the slave address matcher
// Assumes: Master model paces the bus; software side moves just after rising edges
// Notes:   Status is compared whole where every flag is known
`timescale 1ns/1ps
`default_nettype none
module test_i2c_slave_address_match;
   logic                    clock, nrst, clk_en, scl_pin, sda_pin, scl_drive, sda_drive, scl_oe, sda_oe;
   logic                    own_address_we, interrupt_clear, buffer_read, overflow_clear, ack, m_scl, m_sda;
   logic [7:0]              own_address_wdata, own_address_reg, receive_buffer_reg;
   addr_match_pkg::ctrl_s   ctrl;
   addr_match_pkg::status_s status;
   int                      errors = 0, total_checks = 0, tn = 0;
   assign scl_pin = !(m_scl || (scl_oe && !scl_drive));
   assign sda_pin = !(m_sda || (sda_oe && !sda_drive));
   initial begin
      clock = 1'b0;
      forever #4 clock = !clock;
   end
   i2c_slave_address_match i_dut (.clock(clock), .nrst(nrst), .clk_en(clk_en), .scl_pin(scl_pin),
      .scl_drive(scl_drive), .scl_oe(scl_oe), .sda_pin(sda_pin), .sda_drive(sda_drive), .sda_oe(sda_oe), .ctrl(ctrl),
      .own_address_we(own_address_we), .own_address_wdata(own_address_wdata), .interrupt_clear(interrupt_clear),
      .buffer_read(buffer_read), .overflow_clear(overflow_clear), .own_address_reg(own_address_reg),
      .receive_buffer_reg(receive_buffer_reg), .status(status));
   i2c_master_model i_mst (.clock(clock), .scl(scl_pin), .sda(sda_pin), .scl_low(m_scl), .sda_low(m_sda));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Writing the address and pulsing every software clear; ack-time and transmit-ready flags are left as they are
   task automatic sw(input logic [7:0] a);
      own_address_wdata = a;
      {own_address_we, interrupt_clear, buffer_read, overflow_clear} = 4'hF;
      @(posedge clock);
      #1;
      {own_address_we, interrupt_clear, buffer_read, overflow_clear} = 4'h0;
      @(posedge clock);
      #1;
   endtask : sw
   task automatic tx(input logic [7:0] b, input logic [7:0] exp);
      i_mst.send(b, ack);
      chk(8'(ack), exp);
   endtask : tx
   task automatic fin;
      tn++;
      $display("test %0d done", tn);
   endtask : fin
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   initial begin
      #300000;
      errors++;
      close_out;
   end
   initial begin
      {nrst, clk_en, own_address_we, interrupt_clear, buffer_read, overflow_clear} = 6'h10;
      own_address_wdata = 8'h00;
      ctrl = '{addr_match_pkg::MODE_SEVEN, 1'b0, 1'b0, 1'b0, 8'hFF};
      repeat (8) @(posedge clock);
      #1;
      nrst = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk({scl_oe, sda_oe, status}, 8'h00);
      sw(8'hA4);
      i_mst.start;
      tx(8'hA5, 8'h01);
      chk(receive_buffer_reg, 8'hA5);
      chk(8'(status), 8'h29);
      i_mst.start;
      tx(8'hA4, 8'h00);
      chk(8'(status), 8'h2C);
      i_mst.stop;
      fin;
      sw(8'hA4);
      i_mst.start;
      tx(8'hA6, 8'h00);
      chk(8'(status), 8'h00);
      i_mst.stop;
      ctrl.address_mask = 8'hF0;
      i_mst.start;
      tx(8'hAC, 8'h01);
      chk(receive_buffer_reg, 8'hAC);
      i_mst.stop;
      ctrl.address_mask = 8'hFF;
      // A write pulse while the clock enable is low must not land
      clk_en = 1'b0;
      own_address_wdata = 8'h5A;
      own_address_we = 1'b1;
      @(posedge clock);
      #1;
      own_address_we = 1'b0;
      clk_en = 1'b1;
      @(posedge clock);
      #1;
      chk(own_address_reg, 8'hA4);
      fin;
      for (int m = 2; m < 4; m++) begin
         ctrl.slave_mode_select = addr_match_pkg::slave_mode_e'(2'(m));
         sw(8'hA4);
         i_mst.start;
         chk(8'(status), 8'h20);
         sw(8'hA4);
         i_mst.stop;
         chk(8'(status), 8'h20);
      end
      fin;
      ctrl.slave_mode_select = addr_match_pkg::MODE_TEN;
      for (int k = 0; k < 2; k++) begin
         sw(8'hF4);
         i_mst.start;
         tx(8'hF4, 8'h01);
         chk({scl_oe, 1'b0, status}, 8'hB8);
         sw(8'hB5);
         chk({scl_oe, 1'b0, status}, 8'h00);
         tx(8'hB5 - 8'(k), 8'(1 - k));
         chk(8'({scl_oe, status.update_address_flag, status.port_interrupt_flag}), 8'h07);
         sw(8'hF4);
         i_mst.start;
         tx(8'hF5, 8'(1 - k));
         chk(8'(status.transmit_ready), 8'(1 - k));
         i_mst.stop;
      end
      fin;
      ctrl = '{addr_match_pkg::MODE_SEVEN, 1'b1, 1'b0, 1'b1, 8'hFF};
      sw(8'hA4);
      i_mst.start;
      tx(8'hA4, 8'h00);
      i_mst.stop;
      ctrl.software_nack = 1'b0;
      sw(8'hA4);
      i_mst.start;
      tx(8'hA4, 8'h01);
      chk(8'(status), 8'h28);
      i_mst.stop;
      fin;
      close_out;
   end
endmodule : test_i2c_slave_address_match
`default_nettype wire

// [src/addr_match_pkg.sv]
// Purpose: Shared constants and carriers for the two-wire slave address matcher
// Assumes: Byte-wide own address and mask, open-drain bus pins
// Notes:   Mode codes: bit 0 picks 10-bit addressing, bit 1 adds start/stop events
package addr_match_pkg;

   typedef enum logic [1:0] {
      MODE_SEVEN    = 2'h0,
      MODE_TEN      = 2'h1,
      MODE_SEVEN_SP = 2'h2,
      MODE_TEN_SP   = 2'h3
   } slave_mode_e;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_FIRST = 3'h1,
      ST_LOW   = 3'h2,
      ST_DATA  = 3'h3,
      ST_DONE  = 3'h4
   } phase_e;

   localparam logic [4:0] TEN_HIGH_PREFIX = 5'h1E;
   localparam int         MODE_TEN_BIT    = 0;
   localparam int         MODE_SP_BIT     = 1;
   localparam int         TEN_HI_LSB      = 1;
   localparam logic [3:0] BYTE_LAST_BIT   = 4'h8;
   localparam logic [3:0] ACK_SLOT        = 4'h9;
   localparam logic [7:0] OWN_ADDR_RESET  = 8'h00;
   localparam logic [7:0] BUF_RESET       = 8'h00;

   typedef struct packed {
      slave_mode_e slave_mode_select;
      logic        address_hold_enable;
      logic        data_hold_enable;
      logic        software_nack;
      logic [7:0]  address_mask;
   } ctrl_s;

   typedef struct packed {
      logic port_interrupt_flag;
      logic update_address_flag;
      logic buffer_full_flag;
      logic receive_overflow_flag;
      logic acknowledge_time_flag;
      logic transmit_ready;
   } status_s;

endpackage : addr_match_pkg

// [src/i2c_slave_address_match.sv]
// Purpose: Slave address recognition and byte intake for a two-wire bus port
// Assumes: Bus pins are asynchronous and sampled by clock; bus clock far below 125 MHz
// Notes:   Data transmit after a read request is outside this block; only readiness is flagged
//
// Functional notes
// - Four modes: 7-bit or 10-bit, events optional
// - Event modes flag start, restart and stop
// - Compare first byte after any start
// - Match with free buffer loads it and raises interrupt
// - First-byte mismatch goes idle with no visible effect
// - 7-bit compare ignores direction bit
// - 10-bit high byte is 11110, two address bits, 0
// - High byte ack sets update flag, stretches
// - Low byte compares all eight bits
// - Low byte always flags and keeps stretching
// - Own address write clears update flag
// - Restart with read bit starts a read
// - 10-bit read needs full matched pair first
// - Ninth clock is the acknowledge slot
// - Hardware acks when both hold enables clear
// - No ack while buffer full or overflowed
// - Ack-time flag after eighth fall, holds only
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_address_match (
   // Clock, reset, enable
   input  wire logic                   clock,
   input  wire logic                   nrst,
   input  wire logic                   clk_en,
   // Bus pins, open drain
   input  wire logic                   scl_pin,
   output logic                        scl_drive,
   output logic                        scl_oe,
   input  wire logic                   sda_pin,
   output logic                        sda_drive,
   output logic                        sda_oe,
   // Software side
   input  wire addr_match_pkg::ctrl_s  ctrl,
   input  wire logic                   own_address_we,
   input  wire logic [7:0]             own_address_wdata,
   input  wire logic                   interrupt_clear,
   input  wire logic                   buffer_read,
   input  wire logic                   overflow_clear,
   output logic [7:0]                  own_address_reg,
   output logic [7:0]                  receive_buffer_reg,
   output var addr_match_pkg::status_s status
);

   typedef struct packed {
      logic [1:0]              scl_sync;
      logic [1:0]              sda_sync;
      logic                    scl_d;
      logic                    sda_d;
      addr_match_pkg::phase_e  st;
      logic [3:0]              bitcnt;
      logic [7:0]              shift;
      logic                    busy;
      logic                    ten_ok;
      logic                    ack_drv;
      logic                    upd_pend;
      logic                    hold;
      logic [7:0]              own;
      logic [7:0]              rbuf;
      addr_match_pkg::status_s sts;
   } state_s;

   state_s state_reg;
   state_s state_next;

   function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] ref_addr,
                                     input logic [7:0] mask, input logic skip_lsb);
      logic [7:0] care;
      care = mask;
      if (skip_lsb) begin
         care[0] = 1'b0;
      end
      return ((rx ^ ref_addr) & care) == 8'h00;
   endfunction : addr_hit

   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic ten_mode;
   logic sp_mode;
   logic holds_on;
   logic accept;
   logic [7:0] ten_high;

   assign scl_s      = state_reg.scl_sync[1];
   assign sda_s      = state_reg.sda_sync[1];
   assign scl_rise   = scl_s & ~state_reg.scl_d;
   assign scl_fall   = ~scl_s & state_reg.scl_d;
   assign start_cond = scl_s & state_reg.scl_d & ~sda_s & state_reg.sda_d;
   assign stop_cond  = scl_s & state_reg.scl_d & sda_s & ~state_reg.sda_d;
   assign ten_mode   = ctrl.slave_mode_select[addr_match_pkg::MODE_TEN_BIT];
   assign sp_mode    = ctrl.slave_mode_select[addr_match_pkg::MODE_SP_BIT];
   assign holds_on   = ctrl.address_hold_enable | ctrl.data_hold_enable;
   // A byte is taken only while software has drained the previous one
   assign accept     = ~state_reg.sts.buffer_full_flag & ~state_reg.sts.receive_overflow_flag;
   assign ten_high   = {addr_match_pkg::TEN_HIGH_PREFIX,
                        state_reg.own[addr_match_pkg::TEN_HI_LSB+1 -: 2], 1'b0};

   always_comb begin
      logic hit;
      logic rw;
      logic do_ack;
      hit        = 1'b0;
      rw         = state_reg.shift[0];
      do_ack     = 1'b0;
      state_next = state_reg;
      state_next.scl_sync = {state_reg.scl_sync[0], scl_pin};
      state_next.sda_sync = {state_reg.sda_sync[0], sda_pin};
      state_next.scl_d    = scl_s;
      state_next.sda_d    = sda_s;

      // Software side clears; hardware sets below override them
      if (interrupt_clear) begin
         state_next.sts.port_interrupt_flag = 1'b0;
      end
      if (buffer_read) begin
         state_next.sts.buffer_full_flag = 1'b0;
      end
      if (overflow_clear) begin
         state_next.sts.receive_overflow_flag = 1'b0;
      end
      if (own_address_we) begin
         state_next.own                     = own_address_wdata;
         state_next.sts.update_address_flag = 1'b0;
         state_next.hold                    = 1'b0;
      end

      if (start_cond) begin
         state_next.st      = addr_match_pkg::ST_FIRST;
         state_next.bitcnt  = 4'h0;
         state_next.ack_drv = 1'b0;
         state_next.sts.transmit_ready = 1'b0;
         // A restart keeps the completed 10-bit pair for a later read
         if (!state_reg.busy) begin
            state_next.ten_ok = 1'b0;
         end
         state_next.busy = 1'b1;
         if (sp_mode) begin
            state_next.sts.port_interrupt_flag = 1'b1;
         end
      end else if (stop_cond) begin
         state_next.st      = addr_match_pkg::ST_IDLE;
         state_next.busy    = 1'b0;
         state_next.ten_ok  = 1'b0;
         state_next.ack_drv = 1'b0;
         state_next.sts.transmit_ready = 1'b0;
         if (sp_mode) begin
            state_next.sts.port_interrupt_flag = 1'b1;
         end
      end else if (scl_rise && state_reg.st != addr_match_pkg::ST_IDLE
                   && state_reg.bitcnt < addr_match_pkg::BYTE_LAST_BIT) begin
         state_next.shift  = {state_reg.shift[6:0], sda_s};
         state_next.bitcnt = state_reg.bitcnt + 4'h1;
      end else if (scl_fall && state_reg.bitcnt == addr_match_pkg::BYTE_LAST_BIT) begin
         state_next.bitcnt = addr_match_pkg::ACK_SLOT;
         unique case (state_reg.st)
            addr_match_pkg::ST_FIRST: begin
               if (ten_mode) begin
                  hit = addr_hit(state_reg.shift, ten_high, ctrl.address_mask, 1'b1)
                        && (!rw || state_reg.ten_ok);
               end else begin
                  hit = addr_hit(state_reg.shift, state_reg.own, ctrl.address_mask, 1'b1);
               end
               if (!hit) begin
                  state_next.st = addr_match_pkg::ST_IDLE;
               end else if (rw) begin
                  state_next.st = addr_match_pkg::ST_DONE;
                  state_next.sts.transmit_ready = accept;
               end else if (ten_mode) begin
                  state_next.st       = addr_match_pkg::ST_LOW;
                  state_next.upd_pend = accept;
               end else begin
                  state_next.st = addr_match_pkg::ST_DATA;
               end
            end
            addr_match_pkg::ST_LOW: begin
               hit = addr_hit(state_reg.shift, state_reg.own, ctrl.address_mask, 1'b0);
               // Flag and stretch even on a miss so software reloads the high byte
               state_next.sts.port_interrupt_flag = 1'b1;
               state_next.upd_pend = 1'b1;
               state_next.ten_ok   = hit;
               state_next.st       = hit ? addr_match_pkg::ST_DATA : addr_match_pkg::ST_IDLE;
            end
            addr_match_pkg::ST_DATA: begin
               hit = 1'b1;
            end
            addr_match_pkg::ST_IDLE,
            addr_match_pkg::ST_DONE: begin
               hit = 1'b0;
            end
            default: begin
               state_next.st = addr_match_pkg::ST_IDLE;
            end
         endcase
         if (hit) begin
            if (accept) begin
               state_next.rbuf = state_reg.shift;
               state_next.sts.buffer_full_flag    = 1'b1;
               state_next.sts.port_interrupt_flag = 1'b1;
               // With either hold enabled software picks the answer
               do_ack = holds_on ? ~ctrl.software_nack : 1'b1;
            end else begin
               state_next.sts.receive_overflow_flag = 1'b1;
            end
            if (holds_on) begin
               state_next.sts.acknowledge_time_flag = 1'b1;
            end
         end
         state_next.ack_drv = do_ack;
      end else if (scl_fall && state_reg.bitcnt == addr_match_pkg::ACK_SLOT) begin
         state_next.bitcnt  = 4'h0;
         state_next.ack_drv = 1'b0;
         state_next.sts.acknowledge_time_flag = 1'b0;
         if (state_reg.upd_pend) begin
            state_next.upd_pend = 1'b0;
            state_next.sts.update_address_flag = 1'b1;
            state_next.hold     = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg      <= '0;
         state_reg.scl_sync <= 2'h3;
         state_reg.sda_sync <= 2'h3;
         state_reg.scl_d    <= 1'b1;
         state_reg.sda_d    <= 1'b1;
         state_reg.st       <= addr_match_pkg::ST_IDLE;
         state_reg.own      <= addr_match_pkg::OWN_ADDR_RESET;
         state_reg.rbuf     <= addr_match_pkg::BUF_RESET;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   assign scl_drive          = 1'b0;
   assign scl_oe             = state_reg.hold;
   assign sda_drive          = 1'b0;
   assign sda_oe             = state_reg.ack_drv;
   assign own_address_reg    = state_reg.own;
   assign receive_buffer_reg = state_reg.rbuf;
   assign status             = state_reg.sts;

endmodule : i2c_slave_address_match

`default_nettype wire
